// ---- hdl/sarcv_pkg.sv ----
// sarcv_pkg: shared constants and types for the serial conversion-cycle block.
// assumes a 10 MHz system clock; the link pins are asynchronous to it.
package sarcv_pkg;
    // system clock
    localparam int MCLK_PERIOD_NS = 100;          // 10 MHz
    // falling link-clock edge on which the sample is held
    localparam int HOLD_EDGE      = 3;
    // whole link-clock periods added to the select set-up for acquisition
    localparam int ACQ_PERIODS    = 2;
    // leading zeros ahead of the result
    localparam int LEAD_ZEROS     = 4;
    // conversion periods are the resolution plus this many
    localparam int CONV_EXTRA     = 1;
    // least acquisition times, ns, at normal and at low supply
    localparam int T_ACQ_MIN_NS     = 643;
    localparam int T_ACQ_MIN_LOW_NS = 1368;
    // least times rounded up to whole system clocks
    localparam int ACQ_MIN_CYC     = (T_ACQ_MIN_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int ACQ_MIN_LOW_CYC = (T_ACQ_MIN_LOW_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    // edge counter and acquisition timer widths
    localparam int CNT_W = 5;
    localparam int ACQ_W = 5;

    // conversion-cycle phases
    typedef enum logic [1:0] {
        SARCV_DOWN,      // powered down, waiting for select
        SARCV_ACQ,       // tracking the input
        SARCV_CONV,      // holding and shifting the result
        SARCV_DONE       // end of conversion, output released
    } sarcv_state_t;

    // serial output pin as data and enable
    typedef struct packed {
        logic data;
        logic oe;
    } sarcv_pin_t;

    // synchronised link inputs, current and previous
    typedef struct packed {
        logic cs_n;
        logic sclk;
    } sarcv_link_t;
endpackage

// ---- hdl/sarcv_sync.sv ----
// sarcv_sync: two-flop synchroniser for the link pins plus one delayed copy for edge finding.
// assumes inputs are asynchronous to i_clk; only the second stage and its delayed copy feed logic.
`timescale 1ns/1ps
module sarcv_sync
    import sarcv_pkg::*;
#(
    parameter sarcv_link_t RST_VAL = '{cs_n: 1'b1, sclk: 1'b1}
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire sarcv_link_t i_async,
    output sarcv_link_t      o_sync,
    output sarcv_link_t      o_prev
);
    sarcv_link_t meta_reg;   // first stage, read only by the second
    sarcv_link_t sync_reg;   // second stage, safe to use
    sarcv_link_t prev_reg;   // one clock older, for edges

    // pins idle high, so reset to idle to avoid a false edge at release
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_reg <= RST_VAL;
            sync_reg <= RST_VAL;
            prev_reg <= RST_VAL;
        end else begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign o_sync = sync_reg;
    assign o_prev = prev_reg;
endmodule

// ---- hdl/sarcv_top.sv ----
// sarcv_top: conversion-cycle sequencer and serial readout of a small sampling converter.
// assumes the host drives select and link clock as an spi master, mode 3, asynchronous to
// I_MCLK and slow enough (several system clocks per phase) to be sampled; the sampled
// input code stands in for the analog input and is steady around the hold edge.
`timescale 1ns/1ps
module sarcv_top
    import sarcv_pkg::*;
#(
    parameter int RES       = 12,    // result bits: 12, 10 or 8
    parameter bit LOW_SUPPLY = 1'b0  // selects the longer least acquisition time
) (
    input  wire logic           I_MCLK,
    input  wire logic           I_RST,
    input  wire logic           I_CS_N,
    input  wire logic           I_SCLK,
    input  wire logic [RES-1:0] I_SAMPLE_CODE,
    output logic                O_SERIAL_RESULT_OUT,
    output logic                O_SERIAL_RESULT_OUT_OE,
    output logic                O_POWERED,
    output logic                O_HOLD,
    output logic                O_ACQ_SHORT
);
    // end-of-conversion edge and acquisition limit for this variant
    localparam logic [CNT_W-1:0] HOLD_CNT  = CNT_W'(HOLD_EDGE);
    localparam logic [CNT_W-1:0] EOC_EDGE  = CNT_W'(RES + LEAD_ZEROS);
    localparam logic [CNT_W-1:0] MSB_CNT   = CNT_W'(LEAD_ZEROS - 1);
    localparam logic [ACQ_W-1:0] ACQ_LIMIT =
        ACQ_W'(LOW_SUPPLY ? ACQ_MIN_LOW_CYC : ACQ_MIN_CYC);

    sarcv_link_t      link_pins;        // raw pins gathered for the synchroniser
    sarcv_link_t      link_s;           // synchronised pins
    sarcv_link_t      link_p;           // pins one clock older
    sarcv_state_t     state_reg;        // cycle phase
    logic [CNT_W-1:0] edge_cnt_reg;     // falling link edges since select fell
    logic [ACQ_W-1:0] acq_cnt_reg;      // system clocks in acquisition since select fell, saturating
    logic [RES-1:0]   held_reg;         // code captured at hold
    logic [RES-1:0]   shift_reg;        // result still to shift out
    sarcv_pin_t       pin_reg;          // serial output pin
    logic             acq_short_reg;    // last hold came too early
    logic             cs_fall;          // select went active
    logic             cs_rise;          // select released
    logic             sclk_fall;        // gated falling link edge
    logic             hold_evt;         // this edge holds the sample
    logic             eoc_evt;          // this edge ends the conversion
    logic             cnt_evt;          // anything that moves the edge counter

    // both pins go through the same two flops, so their relative order is kept
    assign link_pins = '{cs_n: I_CS_N, sclk: I_SCLK};

    sarcv_sync u_sync (
        .i_clk   (I_MCLK),
        .i_rst   (I_RST),
        .i_async (link_pins),
        .o_sync  (link_s),
        .o_prev  (link_p)
    );

    // edges; link clock counts only while select is low
    assign cs_fall   = link_p.cs_n & ~link_s.cs_n;
    assign cs_rise   = ~link_p.cs_n & link_s.cs_n;
    assign sclk_fall = link_p.sclk & ~link_s.sclk & ~link_s.cs_n;
    assign hold_evt  = sclk_fall && (state_reg == SARCV_ACQ) && (edge_cnt_reg == HOLD_CNT - 1'b1);
    assign eoc_evt   = sclk_fall && (state_reg == SARCV_CONV) && (edge_cnt_reg == EOC_EDGE - 1'b1);
    assign cnt_evt   = cs_fall || sclk_fall;

    // phase sequencing: nothing moves without select and link clock edges
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            state_reg <= SARCV_DOWN;
        end else if (cs_rise) begin
            state_reg <= SARCV_DOWN;
        end else begin
            case (state_reg)
                SARCV_DOWN: begin
                    if (cs_fall) begin
                        state_reg <= SARCV_ACQ;
                    end
                end
                SARCV_ACQ: begin
                    if (hold_evt) begin
                        state_reg <= SARCV_CONV;
                    end
                end
                SARCV_CONV: begin
                    if (eoc_evt) begin
                        state_reg <= SARCV_DONE;
                    end
                end
                SARCV_DONE: begin
                    state_reg <= SARCV_DONE;  // stays in SARCV_DONE, powered down, until select is released
                end
                default: begin
                    state_reg <= SARCV_DOWN;
                end
            endcase
        end
    end

    // falling link edges counted from select; the link clock is the only conversion clock
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            edge_cnt_reg <= '0;
        end else if (cs_fall) begin
            edge_cnt_reg <= '0;
        end else if (sclk_fall && (state_reg == SARCV_ACQ || state_reg == SARCV_CONV)) begin
            edge_cnt_reg <= edge_cnt_reg + 1'b1;
        end
    end

    // acquisition timer; flags a hold that came before the least acquisition time
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            acq_cnt_reg   <= '0;
            acq_short_reg <= 1'b0;
        end else begin
            if (cs_fall) begin
                acq_cnt_reg <= '0;
            end else if (state_reg == SARCV_ACQ && acq_cnt_reg != '1) begin
                acq_cnt_reg <= acq_cnt_reg + 1'b1;
            end
            if (hold_evt && !cs_rise) begin
                acq_short_reg <= (acq_cnt_reg < ACQ_LIMIT);
            end
        end
    end

    // sample held at the third falling edge; the code is passed as straight binary
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            held_reg <= '0;
        end else if (hold_evt && !cs_rise) begin
            held_reg <= I_SAMPLE_CODE;
        end
    end

    // output pin and result shifter; data changes on falling link edges and select edges only
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            pin_reg   <= '{data: 1'b0, oe: 1'b0};
            shift_reg <= '0;
        end else if (cs_rise) begin
            pin_reg   <= '{data: 1'b0, oe: 1'b0};
        end else if (cs_fall) begin
            pin_reg   <= '{data: 1'b0, oe: 1'b1};
        end else if (sclk_fall) begin
            case (state_reg)
                SARCV_ACQ: begin
                    pin_reg.data <= 1'b0;
                    if (hold_evt) begin
                        shift_reg <= I_SAMPLE_CODE;
                    end
                end
                SARCV_CONV: begin
                    if (eoc_evt) begin
                        pin_reg <= '{data: 1'b0, oe: 1'b0};
                    end else begin
                        pin_reg.data <= shift_reg[RES-1];
                        shift_reg    <= {shift_reg[RES-2:0], 1'b0};
                    end
                end
                default: begin
                    pin_reg <= pin_reg;  // clocks after the end change nothing
                end
            endcase
        end
    end

    assign O_SERIAL_RESULT_OUT    = pin_reg.data;
    assign O_SERIAL_RESULT_OUT_OE = pin_reg.oe;
    assign O_POWERED              = (state_reg == SARCV_ACQ) || (state_reg == SARCV_CONV);
    assign O_HOLD                 = (state_reg == SARCV_CONV);
    assign O_ACQ_SHORT            = acq_short_reg;

    // checks
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (I_RST);

    a_idle_stays_down: assert property ((state_reg == SARCV_DOWN) && !cs_fall
        |=> state_reg == SARCV_DOWN) else $error("left power-down without select");
    a_hold_capture: assert property (hold_evt && !cs_rise
        |=> state_reg == SARCV_CONV && held_reg == $past(I_SAMPLE_CODE) && edge_cnt_reg == HOLD_CNT)
        else $error("hold not on third falling edge");
    a_eoc_count: assert property ($rose(state_reg == SARCV_DONE)
        |-> edge_cnt_reg == EOC_EDGE && !pin_reg.oe) else $error("wrong end-of-conversion edge");
    a_cnt_cause: assert property ($changed(edge_cnt_reg) |-> $past(cnt_evt))
        else $error("edge counter moved without link event");
    a_select_enable: assert property (cs_fall |=> pin_reg.oe && !pin_reg.data)
        else $error("output not enabled low at select");
    a_lead_zeros: assert property (sclk_fall && state_reg == SARCV_ACQ && !cs_rise
        |=> !pin_reg.data && pin_reg.oe) else $error("leading zero missing");
    a_msb_first: assert property (sclk_fall && state_reg == SARCV_CONV && edge_cnt_reg == MSB_CNT
        && !cs_rise |=> pin_reg.data == $past(held_reg[RES-1])) else $error("msb not first");
    a_abort_down: assert property (cs_rise |=> state_reg == SARCV_DOWN && !pin_reg.oe)
        else $error("abort did not power down");
    a_data_on_fall: assert property ($changed(pin_reg.data) |-> $past(sclk_fall || cs_fall || cs_rise))
        else $error("data changed off a falling edge");

    c_full_cycle: cover property ($rose(state_reg == SARCV_DONE));
    c_abort_conv: cover property (state_reg == SARCV_CONV && cs_rise);
    c_short_acq:  cover property ($rose(acq_short_reg));
endmodule

// ---- testbench/sarcv_host_model.sv ----
// sarcv_host_model: spi master in mode 3 that stands in for the host controller.
// assumes the bench resolves the serial output wire and calls the tasks off the clock edge.
`timescale 1ns/1ps
module sarcv_host_model #(
    parameter int HALF_NS  = 400,   // half of the 800 ns link clock period
    parameter int SETUP_NS = 500    // select fall to first falling edge
) (
    input  wire logic i_sdo,        // resolved serial output wire
    output logic      o_cs_n,       // select, active low
    output logic      o_sclk        // link clock
);
    logic [19:0] cap_reg;           // sampled bits, newest in bit 0
    int          n_edges;           // falling edges since select fell
    // link idles with select high and the clock standing high
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b1;
        cap_reg = '0;
        n_edges = 0;
    end
    // select fall; the first zero shows before any clock, so sample it just ahead of edge one
    task automatic sel_low();
        o_cs_n = 1'b0;
        n_edges = 0;
        #(SETUP_NS - 10);
        cap_reg = {cap_reg[18:0], i_sdo};
        #10;
    endtask
    // whole clock periods: fall, then sample on the rise
    task automatic clk_edges(input int n);
        repeat (n) begin
            o_sclk = 1'b0;
            n_edges++;
            #(HALF_NS);
            o_sclk = 1'b1;
            cap_reg = {cap_reg[18:0], i_sdo};
            #(HALF_NS);
        end
    endtask
    // short start on purpose: caller picks select set-up and half period, n falls, no sampling
    task automatic fast_edges(input int setup_ns, input int half_ns, input int n);
        o_cs_n = 1'b0;
        n_edges = 0;
        #(setup_ns);
        repeat (n) begin
            o_sclk = 1'b0;
            n_edges++;
            #(half_ns);
            o_sclk = 1'b1;
            #(half_ns);
        end
    endtask
    // release select and wait out half a period before any new cycle
    task automatic sel_high();
        o_cs_n = 1'b1;
        #(HALF_NS);
    endtask
endmodule

// ---- testbench/sarcv_top_tb_top.sv ----
// sarcv_top_tb_top: three resolutions side by side on one shared host link.
// assumes the host model keeps the acquisition and clock rate limits, except in the one
// scenario that cuts acquisition short on purpose to trip the flag.
`timescale 1ns/1ps
module sarcv_top_tb_top;
    import sarcv_pkg::*;
    logic        I_MCLK;                  // 10 MHz system clock
    logic        I_RST;                   // async reset, high
    wire logic   cs_n;                    // host select
    wire logic   sclk;                    // host link clock
    logic [11:0] code;                    // input code, cut per resolution
    wire logic [2:0] dat, oe, pwr, hold, shrt; // index 0, 1, 2 = 12, 10, 8 bits
    wire logic [2:0] sdo_w;               // resolved output wires, z when released
    wire logic   host_sdo;                // the one wire the host listens to
    logic [1:0]  sel;                     // which copy the host listens to
    int          n_fail, checks_done, cycles;
    // one copy per resolution on the shared link; low supply on the 8-bit copy
    // exercises the longer acquisition limit
    for (genvar g = 0; g < 3; g++) begin : g_res
        localparam int RES_G = 12 - 2 * g;
        sarcv_top #(
            .RES        (RES_G),
            .LOW_SUPPLY (1'(g == 2))
        ) sarcv_top_i (
            .I_MCLK                 (I_MCLK),
            .I_RST                  (I_RST),
            .I_CS_N                 (cs_n),
            .I_SCLK                 (sclk),
            .I_SAMPLE_CODE          (code[RES_G-1:0]),
            .O_SERIAL_RESULT_OUT    (dat[g]),
            .O_SERIAL_RESULT_OUT_OE (oe[g]),
            .O_POWERED              (pwr[g]),
            .O_HOLD                 (hold[g]),
            .O_ACQ_SHORT            (shrt[g])
        );
        assign sdo_w[g] = oe[g] ? dat[g] : 1'bz;
    end
    assign host_sdo = sdo_w[sel];
    sarcv_host_model sarcv_host_model_i (
        .i_sdo  (host_sdo),
        .o_cs_n (cs_n),
        .o_sclk (sclk)
    );
    // system clock
    initial begin
        I_MCLK = 1'b0;
        forever #50 I_MCLK = ~I_MCLK;
    end
    // compare and count
    task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // wait n clocks, landing just after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge I_MCLK);
        #5;
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // clocks with select high do nothing; a stopped clock never reaches hold
    task automatic t_ignore();
        sarcv_host_model_i.clk_edges(5);
        tick(4);
        check("idle clocks", {pwr, oe, hold}, 9'h000);
        sarcv_host_model_i.sel_low();
        tick(40);
        check("stopped clock", {pwr, hold}, 6'h38);
        sarcv_host_model_i.sel_high();
        tick(4);
    endtask
    // select raised in mid conversion releases the output and powers down
    task automatic t_abort();
        sarcv_host_model_i.sel_low();
        sarcv_host_model_i.clk_edges(6);
        check("mid conversion", hold, 3'h7);
        sarcv_host_model_i.sel_high();
        tick(5);
        check("abort", {oe, pwr, hold}, 9'h000);
    endtask
    // 100 ns set-up and 600 ns periods reach hold after 13 system clocks: under the
    // low-supply limit only, so the 8-bit copy alone must flag it
    task automatic t_short();
        sarcv_host_model_i.fast_edges(100, 300, HOLD_EDGE);
        check("short acquisition", {hold, shrt}, 6'h3C);
        sarcv_host_model_i.sel_high();
        tick(4);
    endtask
    // one whole cycle on resolution k, then extra clocks past the end
    task automatic t_cycle(input int k, input logic [11:0] v);
        int          r;
        logic [19:0] m;
        r = 12 - 2 * k;
        m = (20'h1 << (r + 4)) - 20'h1;
        code = v;
        sel = 2'(k);
        sarcv_host_model_i.sel_low();
        check("select fall", {pwr[k], oe[k], dat[k], hold[k]}, 4'hC);
        sarcv_host_model_i.clk_edges(2);
        check("tracking", hold[k], 1'b0);
        sarcv_host_model_i.clk_edges(1);
        check("hold edge", {hold[k], shrt[k]}, 2'h2);
        sarcv_host_model_i.clk_edges(r);
        check("result", sarcv_host_model_i.cap_reg & m, 20'(v) & (m >> 4));
        check("lsb driven", oe[k], 1'b1);
        sarcv_host_model_i.clk_edges(1);
        check("end of conversion", {oe[k], pwr[k], hold[k]}, 3'h0);
        sarcv_host_model_i.clk_edges(2);
        check("after end", {oe[k], pwr[k]}, 2'h0);
        sarcv_host_model_i.sel_high();
        tick(4);
    endtask
    // main sequence: zero, midscale, full scale and a pattern on each resolution
    initial begin
        I_RST = 1'b1;
        code = '0;
        sel = '0;
        n_fail = 0;
        checks_done = 0;
        cycles = 0;
        tick(6);
        I_RST = 1'b0;
        tick(2);
        check("reset", {oe, pwr, hold, shrt}, 12'h000);
        t_ignore();
        t_abort();
        t_short();
        for (int k = 0; k < 3; k++) begin
            t_cycle(k, 12'h000);
            t_cycle(k, 12'(1 << (11 - 2 * k)));
            t_cycle(k, 12'hFFF);
            t_cycle(k, 12'h5A6);
        end
        complete_run();
    end
    // hang guard, well above the expected 1900 or so clocks
    always @(posedge I_MCLK) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            n_fail++;
            complete_run();
        end
    end
endmodule
